//--- async_ctrl_fifo_port_consts.vh
// Constants for the host byte port to the control packet FIFOs
`ifndef ASYNC_CTRL_FIFO_PORT_CONSTS_VH
`define ASYNC_CTRL_FIFO_PORT_CONSTS_VH
// Byte addresses on the host bus
`define ADDR_RETRY_PRIO 8'h4C
`define ADDR_ACK_STATUS 8'h31
`define ADDR_TX_FC 8'h50
`define ADDR_TX_LAST 8'h54
`define ADDR_RX_WORD 8'h5C
// Field positions in Verilog bit order (bit 31 = most significant)
`define RETRY_MAX_HI 27
`define RETRY_MAX_LO 24
`define RETRY_GAP_HI 23
`define RETRY_GAP_LO 16
`define PRIO_CEIL_HI 10
`define PRIO_CEIL_LO 8
`define BUDGET_EN_BIT 6
`define PRIO_ALLOT_HI 5
`define PRIO_ALLOT_LO 0
// Writable bits of the retry/priority register
`define RETRY_PRIO_WMASK 32'h0FFF077F
// Reset values
`define RETRY_PRIO_RESET 32'h00000000
`define QUAD_RESET 32'h00000000
`define ACK_CODE_RESET 5'h00
// Acknowledge code reported after the resend budget is spent
`define ACK_TIMEOUT_CODE 5'h1F
// Byte lane of the last byte in a stacking buffer
`define LAST_LANE 2'h3
// Transmit FIFO geometry
`define TX_FIFO_DEPTH 32
`define TX_FIFO_AW 5
`endif

//--- quad_fifo.v
// Quadlet FIFO with registered output stage and registered input ready
`timescale 1ns/1ns
module quad_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
  reg [AW-1:0] wptr; // Write pointer
  reg [AW-1:0] rptr; // Read pointer
  reg [AW:0] count; // Words held in storage
  reg [AW:0] next_count; // Count after this cycle
  wire push; // Word accepted from the source
  wire pop; // Word moved into the output stage
  assign push = in_valid && in_ready;
  assign pop = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  // Next occupancy, so that ready can be a flop and still be honest
  always @*
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  // Pointers, storage and output stage
  always @(posedge clk)
  begin
    if (rst)
    begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else
    begin
      count <= next_count;
      in_ready <= (next_count != DEPTH[AW:0]);
      if (push)
      begin
        mem[wptr] <= in_data;
        wptr <= wptr + 1'b1;
      end
      if (pop)
      begin
        out_data <= mem[rptr];
        out_valid <= 1'b1;
        rptr <= rptr + 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0; // Drained, nothing behind it
    end
  end
endmodule // quad_fifo

//--- async_ctrl_fifo_port.v
// Host byte port to control FIFOs and retry/priority settings
`timescale 1ns/1ns
`include "async_ctrl_fifo_port_consts.vh"
//
// Function
// [R1] Resend busy packets up to retry limit
// [R2] Spent retries: raise irq, report timeout code
// [R3] Retry limit mirrored to busy timeout CSR
// [R4] Retry spacing counted in isochronous cycles
// [R5] Priority ceiling resets zero, host sets it
// [R6] Priority ceiling mirrored to budget CSR
// [R7] Budget arbitration starts only when enabled
// [R8] Priority allotment mirrored to budget CSR
// [R9] FIFO words move only as full quadlets
// [R10] Host writes first-continue bytes in order
// [R11] Lowest address holds most significant byte
// [R12] First-continue quadlets pushed to transmit FIFO
// [R13] Update quadlet ends packet, confirms transmit
// [R14] Host writes update bytes in order
// [R15] Receive register presents received quadlet bytes
// [R16] Registers and data zero after reset
// [R17] Acknowledge code stored when ack arrives
// [R18] Base address access restarts byte position
// [R19] Receive FIFO advances after last byte read
module async_ctrl_fifo_port #(
  parameter DEPTH = `TX_FIFO_DEPTH,
  parameter AW = `TX_FIFO_AW
) (
  input wire clk,
  input wire rst,
  input wire [7:0] host_addr,
  input wire host_wr,
  input wire host_rd,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata,
  output reg host_tx_ready,
  output reg [31:0] tx_word,
  output reg tx_word_last,
  output reg tx_word_valid,
  input wire tx_word_ready,
  output reg pkt_confirm,
  input wire ack_valid,
  input wire [4:0] ack_code,
  input wire ack_busy,
  input wire iso_cycle_tick,
  output reg resend_req,
  output reg [4:0] tx_ack_code,
  output reg tx_ack_irq,
  output reg [3:0] busy_timeout_limit,
  output reg [2:0] pri_max,
  output reg [5:0] pri_req,
  output reg budget_arb_enable,
  output reg budget_arb_start,
  input wire [31:0] rx_in_data,
  input wire rx_in_valid,
  output reg rx_in_ready
);
  // Retry engine states
  localparam ST_IDLE = 2'd0;
  localparam ST_GAP = 2'd1;
  localparam ST_RESEND = 2'd2;

  reg [31:0] retry_prio; // Retry/priority budget register
  reg [31:0] fc_stack; // First-continue stacking buffer
  reg [31:0] last_stack; // Update stacking buffer
  reg [31:0] rx_word; // Receive quadlet being read out
  reg rx_full; // Receive quadlet held
  reg [1:0] state; // Retry engine state
  reg [3:0] tries; // Resends used for current packet
  reg [7:0] gap_count; // Iso cycles waited since busy ack
  reg fifo_push; // Quadlet push strobe
  reg fifo_push_last; // Pushed quadlet ends a packet
  reg [31:0] fifo_push_data; // Quadlet being pushed
  reg budget_en_d; // Enable seen last cycle
  wire fifo_in_ready; // Transmit FIFO can accept
  wire [32:0] fifo_out; // FIFO output word with last flag
  wire fifo_out_valid; // FIFO output stage holds a word
  wire [1:0] lane; // Byte lane from address low bits
  wire [3:0] retry_max; // Retry limit field
  wire [7:0] retry_gap; // Retry interval field
  wire wr_fc; // Write into first-continue buffer
  wire wr_last; // Write into update buffer
  wire rd_rx; // Read of receive quadlet
  wire wr_reg; // Write into retry/priority register
  reg [31:0] next_retry_prio; // Register after byte write

  assign lane = host_addr[1:0];
  assign retry_max = retry_prio[`RETRY_MAX_HI:`RETRY_MAX_LO];
  assign retry_gap = retry_prio[`RETRY_GAP_HI:`RETRY_GAP_LO];
  assign wr_fc = host_wr && (base_of(host_addr) == `ADDR_TX_FC);
  assign wr_last = host_wr && (base_of(host_addr) == `ADDR_TX_LAST);
  assign rd_rx = host_rd && (base_of(host_addr) == `ADDR_RX_WORD);
  assign wr_reg = host_wr && (base_of(host_addr) == `ADDR_RETRY_PRIO);

  // Quadlet base address of a byte address, used by every decode except the acknowledge status byte
  function [7:0] base_of;
    input [7:0] a;
    begin
      base_of = {a[7:2], 2'b00};
    end
  endfunction

  // Pick a byte of a quadlet; lane 0 is the most significant byte
  function [7:0] lane_byte;
    input [31:0] q;
    input [1:0] l;
    begin
      case (l)
        2'd0: lane_byte = q[31:24]; // [R11]
        2'd1: lane_byte = q[23:16];
        2'd2: lane_byte = q[15:8];
        default: lane_byte = q[7:0];
      endcase
    end
  endfunction

  // Place a byte into a quadlet at its lane, other lanes kept
  function [31:0] put_byte;
    input [31:0] q;
    input [1:0] l;
    input [7:0] b;
    begin
      put_byte = q;
      case (l)
        2'd0: put_byte[31:24] = b; // [R11]
        2'd1: put_byte[23:16] = b;
        2'd2: put_byte[15:8] = b;
        default: put_byte[7:0] = b;
      endcase
    end
  endfunction

  // Byte write into the retry/priority register, reserved bits held zero
  always @*
  begin
    next_retry_prio = retry_prio;
    if (wr_reg)
      next_retry_prio = put_byte(retry_prio, lane, host_wdata)
        & `RETRY_PRIO_WMASK;
  end

  // Transmit FIFO; ready back-pressures the host through host_tx_ready
  quad_fifo #(
    .WIDTH(33),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .in_data({fifo_push_last, fifo_push_data}),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(tx_word_ready || !tx_word_valid)
  );

  // Register file and mirrors of its fields toward the link
  always @(posedge clk)
  begin
    if (rst)
    begin
      retry_prio <= `RETRY_PRIO_RESET; // [R16] [R5]
      busy_timeout_limit <= 4'h0;
      pri_max <= 3'h0;
      pri_req <= 6'h00;
      budget_arb_enable <= 1'b0;
      budget_en_d <= 1'b0;
      budget_arb_start <= 1'b0;
    end
    else
    begin
      retry_prio <= next_retry_prio;
      // Ceiling is three bits wide, so 7 is the most it can hold
      busy_timeout_limit <=
        next_retry_prio[`RETRY_MAX_HI:`RETRY_MAX_LO]; // [R3]
      pri_max <= next_retry_prio[`PRIO_CEIL_HI:`PRIO_CEIL_LO]; // [R6] [R5]
      pri_req <= next_retry_prio[`PRIO_ALLOT_HI:`PRIO_ALLOT_LO]; // [R8]
      budget_arb_enable <= next_retry_prio[`BUDGET_EN_BIT]; // [R7]
      budget_en_d <= retry_prio[`BUDGET_EN_BIT];
      // One pulse when arbitration is first allowed to begin
      budget_arb_start <= retry_prio[`BUDGET_EN_BIT] && !budget_en_d; // [R7]
    end
  end

  // Stacking buffers for the transmit side
  always @(posedge clk)
  begin
    if (rst)
    begin
      fc_stack <= `QUAD_RESET; // [R16]
      last_stack <= `QUAD_RESET;
      fifo_push <= 1'b0;
      fifo_push_last <= 1'b0;
      fifo_push_data <= `QUAD_RESET;
      pkt_confirm <= 1'b0;
      host_tx_ready <= 1'b1;
    end
    else
    begin
      fifo_push <= 1'b0;
      pkt_confirm <= 1'b0;
      host_tx_ready <= fifo_in_ready;
      if (wr_fc)
      begin
        // Base byte starts a fresh quadlet; stale bytes cleared
        if (lane == 2'd0)
          fc_stack <= put_byte(`QUAD_RESET, lane, host_wdata); // [R18]
        else
          fc_stack <= put_byte(fc_stack, lane, host_wdata); // [R10]
        // Only the last byte moves a whole quadlet onward
        if (lane == `LAST_LANE)
        begin
          fifo_push <= 1'b1; // [R9] [R12]
          fifo_push_last <= 1'b0;
          fifo_push_data <= put_byte(fc_stack, lane, host_wdata);
        end
      end
      if (wr_last)
      begin
        if (lane == 2'd0)
          last_stack <= put_byte(`QUAD_RESET, lane, host_wdata); // [R18]
        else
          last_stack <= put_byte(last_stack, lane, host_wdata); // [R14]
        if (lane == `LAST_LANE)
        begin
          fifo_push <= 1'b1; // [R9] [R13]
          fifo_push_last <= 1'b1;
          fifo_push_data <= put_byte(last_stack, lane, host_wdata);
          pkt_confirm <= 1'b1; // [R13]
        end
      end
    end
  end

  // Output stage toward the link
  always @(posedge clk)
  begin
    if (rst)
    begin
      tx_word <= `QUAD_RESET;
      tx_word_last <= 1'b0;
      tx_word_valid <= 1'b0;
    end
    else if (tx_word_ready || !tx_word_valid)
    begin
      tx_word <= fifo_out[31:0];
      tx_word_last <= fifo_out[32];
      tx_word_valid <= fifo_out_valid;
    end
  end

  // Receive holding quadlet; freed only after its last byte is read
  always @(posedge clk)
  begin
    if (rst)
    begin
      rx_word <= `QUAD_RESET; // [R16]
      rx_full <= 1'b0;
      rx_in_ready <= 1'b1;
    end
    else
    begin
      if (rx_in_valid && rx_in_ready)
      begin
        rx_word <= rx_in_data; // [R15]
        rx_full <= 1'b1;
        rx_in_ready <= 1'b0;
      end
      else if (rd_rx && lane == `LAST_LANE && rx_full)
      begin
        rx_full <= 1'b0; // [R19]
        rx_in_ready <= 1'b1;
      end
    end
  end

  // Host read data, one cycle after the read strobe
  always @(posedge clk)
  begin
    if (rst)
      host_rdata <= 8'h00;
    else if (host_rd)
    begin
      if (base_of(host_addr) == `ADDR_RETRY_PRIO)
        host_rdata <= lane_byte(retry_prio, lane);
      else if (host_addr == `ADDR_ACK_STATUS)
        host_rdata <= {3'b000, tx_ack_code}; // [R17]
      else if (base_of(host_addr) == `ADDR_TX_LAST)
        host_rdata <= lane_byte(last_stack, lane);
      else if (base_of(host_addr) == `ADDR_RX_WORD)
        host_rdata <= lane_byte(rx_word, lane); // [R15] [R11]
      else
        host_rdata <= 8'h00; // Unmapped and write-only read zero
    end
  end

  // Retry engine: busy acks trigger spaced resends until limit
  always @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      tries <= 4'h0;
      gap_count <= 8'h00;
      resend_req <= 1'b0;
      tx_ack_code <= `ACK_CODE_RESET;
      tx_ack_irq <= 1'b0;
    end
    else
    begin
      resend_req <= 1'b0;
      tx_ack_irq <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (ack_valid && ack_busy && tries < retry_max)
          begin
            state <= ST_GAP; // [R1]
            gap_count <= 8'h00;
          end
          else if (ack_valid && ack_busy)
          begin
            // Budget spent: give up and report a timeout
            tx_ack_code <= `ACK_TIMEOUT_CODE; // [R2]
            tx_ack_irq <= 1'b1; // [R2]
            tries <= 4'h0;
          end
          else if (ack_valid)
          begin
            tx_ack_code <= ack_code; // [R17]
            tx_ack_irq <= 1'b1;
            tries <= 4'h0;
          end
        end
        ST_GAP:
        begin
          // Zero interval resends at once; else wait whole iso cycles
          if (gap_count >= retry_gap)
            state <= ST_RESEND; // [R4]
          else if (iso_cycle_tick)
            gap_count <= gap_count + 8'h01; // [R4]
        end
        ST_RESEND:
        begin
          resend_req <= 1'b1; // [R1]
          tries <= tries + 4'h1;
          state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule // async_ctrl_fifo_port

//--- link_model.sv
// Link-side partner: transmit sink, receive source, acknowledge driver
`timescale 1ns/1ns
module link_model (
  input wire clk,
  input wire rst,
  input wire [31:0] tx_word,
  input wire tx_word_last,
  input wire tx_word_valid,
  output reg tx_word_ready,
  output reg [31:0] rx_in_data,
  output reg rx_in_valid,
  input wire rx_in_ready,
  output reg ack_valid,
  output reg [4:0] ack_code,
  output reg ack_busy,
  output reg iso_cycle_tick
);
  reg stall = 1'b0; // Set by the bench to hold off the sink
  logic [32:0] got[$]; // Received {last, word}
  logic [31:0] rx_q[$]; // Words waiting to be offered
  initial
  begin
    tx_word_ready = 1'b0;
    rx_in_data = 32'h00000000;
    rx_in_valid = 1'b0;
    ack_valid = 1'b0;
    ack_code = 5'h00;
    ack_busy = 1'b0;
    iso_cycle_tick = 1'b0;
  end
  // Sink and source; idle data toggles so stale values never match
  always @(posedge clk)
  begin
    tx_word_ready <= !stall && !rst; // No sink while the port is in reset
    if (tx_word_valid && tx_word_ready)
      got.push_back({tx_word_last, tx_word});
    if (rx_in_valid && rx_in_ready)
      rx_in_valid <= 1'b0;
    else if (!rx_in_valid && rx_q.size() > 0)
    begin
      rx_in_data <= rx_q.pop_front();
      rx_in_valid <= 1'b1;
    end
    else if (!rx_in_valid)
      rx_in_data <= ~rx_in_data;
  end
  // One acknowledge pulse
  task ack(input b, input [4:0] c);
    @(posedge clk);
    ack_busy <= b;
    ack_code <= c;
    ack_valid <= 1'b1;
    @(posedge clk);
    ack_valid <= 1'b0;
    ack_code <= ~c;
  endtask
  // One isochronous cycle mark
  task tick;
    @(posedge clk);
    iso_cycle_tick <= 1'b1;
    @(posedge clk);
    iso_cycle_tick <= 1'b0;
  endtask
endmodule // link_model

//--- async_ctrl_fifo_port_assertions.sv
// Port-level checker for the host byte port
`timescale 1ns/1ns
module acfp_chk (
  input wire clk,
  input wire rst,
  input wire [7:0] host_addr,
  input wire host_wr,
  input wire [7:0] host_wdata,
  input wire pkt_confirm,
  input wire ack_valid,
  input wire ack_busy,
  input wire [4:0] tx_ack_code,
  input wire tx_ack_irq,
  input wire [3:0] busy_timeout_limit,
  input wire [2:0] pri_max,
  input wire [5:0] pri_req,
  input wire budget_arb_enable,
  input wire budget_arb_start,
  input wire rx_in_valid,
  input wire rx_in_ready,
  input wire [31:0] tx_word,
  input wire tx_word_valid,
  input wire tx_word_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_confirm_on_last: assert property (
    host_wr && host_addr == 8'h57 |=> pkt_confirm) else $error("no confirm");
  a_confirm_cause: assert property (
    pkt_confirm |-> $past(host_wr) && $past(host_addr) == 8'h57)
    else $error("stray confirm");
  a_limit_mirror: assert property (
    host_wr && host_addr == 8'h4C |=>
    {4'h0, busy_timeout_limit} == ($past(host_wdata) & 8'h0F))
    else $error("limit mirror");
  a_ceiling_mirror: assert property (
    host_wr && host_addr == 8'h4E |=>
    {5'h00, pri_max} == ($past(host_wdata) & 8'h07))
    else $error("ceiling mirror");
  a_allot_mirror: assert property (
    host_wr && host_addr == 8'h4F |=>
    {1'b0, budget_arb_enable, pri_req} == ($past(host_wdata) & 8'h7F))
    else $error("allotment mirror");
  a_start_enabled: assert property (
    budget_arb_start |-> budget_arb_enable) else $error("start disabled");
  a_zero_timeout: assert property (
    ack_valid && ack_busy && busy_timeout_limit == 4'h0 |->
    ##[1:3] tx_ack_irq && tx_ack_code == 5'h1F) else $error("no timeout");
  a_rx_take_once: assert property (
    rx_in_valid && rx_in_ready |=> !rx_in_ready) else $error("rx ready");
  a_tx_word_hold: assert property (
    tx_word_valid && !tx_word_ready |=> tx_word_valid && $stable(tx_word))
    else $error("tx word moved");
endmodule // acfp_chk
bind async_ctrl_fifo_port acfp_chk u_chk (.*);

//--- testbench.sv
// Self-checking bench for the host byte port
`timescale 1ns/1ns
module testbench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] host_addr = 8'h00;
  reg host_wr = 1'b0;
  reg host_rd = 1'b0;
  reg [7:0] host_wdata = 8'h00;
  wire [7:0] host_rdata;
  wire [31:0] tx_word, rx_in_data;
  wire [4:0] ack_code, tx_ack_code;
  wire [3:0] busy_timeout_limit;
  wire [2:0] pri_max;
  wire [5:0] pri_req;
  wire host_tx_ready, tx_word_last, tx_word_valid, tx_word_ready;
  wire pkt_confirm, ack_valid, ack_busy, iso_cycle_tick, resend_req;
  wire tx_ack_irq, budget_arb_enable, budget_arb_start;
  wire rx_in_valid, rx_in_ready;
  int n_errors = 0;
  int comparisons = 0;
  int n_confirm = 0, n_resend = 0, n_irq = 0, n_start = 0; // Pulse tallies
  always #20 clk = ~clk;
  async_ctrl_fifo_port dut (.*);
  link_model u_link (.*);
  // Pulses are counted here so no single-cycle event is missed
  always @(posedge clk)
  begin
    n_confirm += (pkt_confirm === 1'b1);
    n_resend += (resend_req === 1'b1);
    n_irq += (tx_ack_irq === 1'b1);
    n_start += (budget_arb_start === 1'b1);
  end
  task chk(input [32:0] got, input [32:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    #1 d = host_rdata;
  endtask
  // Whole quadlets, base byte first, most significant byte first
  task wq(input [7:0] a, input [31:0] q);
    for (int i = 0; i < 4; i++)
      wr(a + 8'(i), q[31 - 8 * i -: 8]);
  endtask
  task rq(input [7:0] a, output [31:0] q);
    reg [7:0] b;
    for (int i = 0; i < 4; i++)
    begin
      rd(a + 8'(i), b);
      q = {q[23:0], b};
    end
  endtask
  task t_reset;
    reg [31:0] q;
    rq(8'h4C, q);
    chk(q, 0);
    rq(8'h54, q);
    chk(q, 0);
    rq(8'h5C, q);
    chk(q, 0);
    chk({tx_word_valid, tx_ack_code}, 0);
  endtask
  task t_regs;
    reg [31:0] q;
    wq(8'h4C, 32'h0302056A);
    idle(4);
    chk({busy_timeout_limit, pri_max, pri_req, budget_arb_enable},
      {4'h3, 3'h5, 6'h2A, 1'b1});
    chk(n_start, 1);
    wq(8'h4C, 32'hFFFFFFFF);
    rq(8'h4C, q);
    chk(q, 32'h0FFF077F);
    wq(8'h4C, 32'h02020000);
    rq(8'h4C, q);
    chk(q, 32'h02020000);
  endtask
  // Fill with the sink stalled, drain, then close the packet
  task t_tx;
    int n;
    int k;
    u_link.stall <= 1'b1;
    wr(8'h50, 8'hEE);
    wr(8'h51, 8'hEE);
    n = 0;
    while (host_tx_ready === 1'b1 && n < 40)
    begin
      wq(8'h50, 32'h01000000 + n);
      n++;
      // Ready lags the last push by two edges; let it settle first
      idle(3);
    end
    chk(n >= 32, 1);
    u_link.stall <= 1'b0;
    k = 0;
    while (u_link.got.size() < n && k < 400)
    begin
      idle(1);
      k++;
    end
    wq(8'h54, 32'hA1B2C3D4);
    idle(12);
    chk(n_confirm, 1);
    chk(u_link.got.size(), n + 1);
    for (k = 0; k < n; k++)
      chk(u_link.got[k], 33'h001000000 + k);
    chk(u_link.got[n], 33'h1A1B2C3D4);
  endtask
  task t_rx;
    reg [31:0] q;
    reg [7:0] b;
    u_link.rx_q.push_back(32'h5A6B7C8D);
    u_link.rx_q.push_back(32'h1F2E3D4C);
    idle(6);
    rd(8'h58, b);
    chk(b, 0);
    rd(8'h5C, b);
    rd(8'h5D, b);
    chk(rx_in_ready, 0);
    rq(8'h5C, q);
    chk(q, 32'h5A6B7C8D);
    idle(6);
    rq(8'h5C, q);
    chk(q, 32'h1F2E3D4C);
  endtask
  task t_retry;
    int r;
    reg [7:0] b;
    for (int k = 0; k < 2; k++)
    begin
      r = n_resend;
      u_link.ack(1'b1, 5'h00);
      u_link.tick;
      idle(6);
      chk(n_resend - r, 0);
      u_link.tick;
      idle(6);
      chk(n_resend - r, 1);
    end
    r = n_irq;
    u_link.ack(1'b1, 5'h00);
    idle(6);
    chk(n_irq - r, 1);
    chk(tx_ack_code, 5'h1F);
    u_link.ack(1'b0, 5'h0B);
    idle(4);
    rd(8'h31, b);
    chk(n_irq - r, 2);
    chk(b, 8'h0B);
    wr(8'h4C, 8'h00);
    r = n_resend;
    u_link.ack(1'b1, 5'h00);
    idle(6);
    chk(n_resend - r, 0);
    chk(tx_ack_code, 5'h1F);
  endtask
  task end_of_test;
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #(40 * 20000);
    n_errors++;
    end_of_test;
  end
  initial
  begin
    idle(20);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_tx;
    t_rx;
    t_retry;
    end_of_test;
  end
endmodule // testbench
